// ---- hw/iac_abort_status.sv ----
// abort cause recorder, receive level and SDA hold register
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module iac_abort_status (
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire iac_pkg::iac_bus_req_t  bus_req,
  output logic [31:0]                 rd_data,
  input  wire iac_pkg::iac_ctrl_t     ctrl,
  input  wire iac_pkg::iac_evt_t      evt,
  input  wire logic [5:0]             rx_fifo_count,
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic [15:0]                 sda_hold_cycles,
  output logic [15:0]                 tx_abort_cause,
  output logic                        tx_abort_event,
  output logic                        tx_fifo_flush
);

  // ******************************************************************
  // state
  // ******************************************************************
  typedef struct packed {
    logic [15:0] cause;
    logic [15:0] sda_hold;
    logic [5:0]  rx_count;
    logic [31:0] rdata;
    logic        abort;
    logic        flush;
  } iac_core_state_t;

  iac_core_state_t st_reg;
  iac_core_state_t st_next;

  logic        scl_rise;
  logic        sda_level;
  logic        line_mismatch;
  logic        master_lost;
  logic        slave_lost;
  logic        sbyte_cause;
  logic        clear_hit;
  logic [15:0] set_bits;
  logic [15:0] kept_bits;
  logic [15:0] clear_mask;

  // ******************************************************************
  // helpers
  // ******************************************************************
  function automatic logic hit(input logic [31:0] a, input logic [31:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [15:0] bit_at(input int unsigned pos, input logic v);
    logic [15:0] m;
    m      = 16'h0000;
    m[pos] = v;
    bit_at = m;
  endfunction

  function automatic logic unacked(input iac_pkg::iac_evt_t e,
                                   input iac_pkg::iac_phase_t ph);
    unacked = e.ack_strobe & ~e.acked & (e.ack_phase == ph);
  endfunction

  function automatic logic acked_in(input iac_pkg::iac_evt_t e,
                                    input iac_pkg::iac_phase_t ph);
    acked_in = e.ack_strobe & e.acked & (e.ack_phase == ph);
  endfunction

  // ******************************************************************
  // bus line sampling
  // ******************************************************************
  iac_line_sync u_line_sync (
    .clock     (clock),
    .nrst      (nrst),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .scl_rise  (scl_rise),
    .sda_level (sda_level)
  );

  // a released high that reads back low means someone else drives
  assign line_mismatch = scl_rise & (sda_level != evt.intended_sda);

  // master and slave roles are checked side by side
  assign master_lost = line_mismatch & evt.master_tx;
  assign slave_lost  = line_mismatch & evt.slave_tx;

  // START byte misuse is a level: it stays while the command waits
  assign sbyte_cause = evt.master_req_pending & ~ctrl.repeated_start_allow
                     & ctrl.command_select_a & ctrl.gcall_or_startbyte_select;

  assign clear_hit = bus_req.wr & hit(bus_req.addr, iac_pkg::TX_ABORT_CLEAR_OFS);

  // ******************************************************************
  // cause detection
  // ******************************************************************
  always_comb begin
    set_bits = 16'h0000;

    // slave side
    set_bits |= bit_at(iac_pkg::SLAVE_READ_CMD_CONFLICT,
                       evt.slave_read_req & evt.cmd_write
                       & evt.cmd_read_bit);
    set_bits |= bit_at(iac_pkg::SLAVE_TX_BUS_LOST, slave_lost);
    set_bits |= bit_at(iac_pkg::ARBITRATION_LOST, slave_lost);
    set_bits |= bit_at(iac_pkg::SLAVE_STALE_TX_FLUSH,
                       evt.slave_read_cmd_rx & evt.tx_fifo_nonempty);

    // master arbitration
    set_bits |= bit_at(iac_pkg::ARBITRATION_LOST, master_lost);

    // master start checks
    set_bits |= bit_at(iac_pkg::MASTER_DISABLED_ATTEMPT,
                       evt.master_start & ~ctrl.master_enable);
    set_bits |= bit_at(iac_pkg::TENBIT_READ_NO_RESTART,
                       evt.master_start & ctrl.master_enable
                       & ~ctrl.repeated_start_allow & ctrl.tenbit_addr
                       & evt.first_cmd_read);
    set_bits |= bit_at(iac_pkg::STARTBYTE_NO_RESTART, sbyte_cause);
    set_bits |= bit_at(iac_pkg::HIGHSPEED_NO_RESTART,
                       evt.master_start & ctrl.master_enable
                       & ~ctrl.repeated_start_allow & ctrl.highspeed);

    // acknowledge phase results
    set_bits |= bit_at(iac_pkg::STARTBYTE_ACKED,
                       acked_in(evt, iac_pkg::IAC_PH_SBYTE));
    set_bits |= bit_at(iac_pkg::HIGHSPEED_CODE_ACKED,
                       acked_in(evt, iac_pkg::IAC_PH_HSCODE));
    set_bits |= bit_at(iac_pkg::GCALL_FOLLOWED_BY_READ,
                       acked_in(evt, iac_pkg::IAC_PH_GCALL)
                       & evt.next_cmd_bit9);
    set_bits |= bit_at(iac_pkg::GCALL_UNACKED,
                       unacked(evt, iac_pkg::IAC_PH_GCALL));
    set_bits |= bit_at(iac_pkg::TX_DATA_UNACKED,
                       unacked(evt, iac_pkg::IAC_PH_DATA));
    set_bits |= bit_at(iac_pkg::TENBIT_ADDR_SECOND_UNACKED,
                       unacked(evt, iac_pkg::IAC_PH_ADDR10B));
    set_bits |= bit_at(iac_pkg::TENBIT_ADDR_FIRST_UNACKED,
                       unacked(evt, iac_pkg::IAC_PH_ADDR10A));
    set_bits |= bit_at(iac_pkg::SEVENBIT_ADDR_UNACKED,
                       unacked(evt, iac_pkg::IAC_PH_ADDR7));
  end

  // ******************************************************************
  // clear and merge
  // ******************************************************************
  always_comb begin
    clear_mask = clear_hit ? 16'hFFFF : 16'h0000;
    kept_bits  = st_reg.cause & ~clear_mask;
  end

  // ******************************************************************
  // next state
  // ******************************************************************
  always_comb begin
    st_next          = st_reg;
    st_next.rx_count = rx_fifo_count;

    // set wins over clear, except bit 9 which drops for the clear cycle
    st_next.cause = kept_bits | set_bits;
    if (clear_hit) begin
      st_next.cause[iac_pkg::STARTBYTE_NO_RESTART] = 1'b0;
    end

    st_next.abort = |st_next.cause;
    st_next.flush = |(st_next.cause & ~st_reg.cause);

    if (bus_req.wr && hit(bus_req.addr, iac_pkg::SDA_HOLD_TIME_OFS)) begin
      st_next.sda_hold = bus_req.wdata[15:0];
    end

    // read data stand for the one cycle after the strobe only
    st_next.rdata = 32'h0000_0000;
    if (bus_req.rd) begin
      if (hit(bus_req.addr, iac_pkg::RX_FIFO_FILL_COUNT_OFS)) begin
        st_next.rdata = {26'h0000000, st_reg.rx_count};
      end else if (hit(bus_req.addr, iac_pkg::SDA_HOLD_TIME_OFS)) begin
        st_next.rdata = {16'h0000, st_reg.sda_hold};
      end else if (hit(bus_req.addr, iac_pkg::TX_ABORT_CAUSE_OFS)) begin
        st_next.rdata = {16'h0000, st_reg.cause};
      end else begin
        st_next.rdata = iac_pkg::UNMAPPED_RDATA;
      end
    end
  end

  // ******************************************************************
  // registers
  // ******************************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_reg.cause    <= iac_pkg::ABORT_CAUSE_RST;
      st_reg.sda_hold <= iac_pkg::SDA_HOLD_RST;
      st_reg.rx_count <= iac_pkg::RX_COUNT_RST;
      st_reg.rdata    <= 32'h0000_0000;
      st_reg.abort    <= 1'b0;
      st_reg.flush    <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ******************************************************************
  // outputs
  // ******************************************************************
  assign rd_data         = st_reg.rdata;
  assign sda_hold_cycles = st_reg.sda_hold;
  assign tx_abort_cause  = st_reg.cause;
  assign tx_abort_event  = st_reg.abort;
  assign tx_fifo_flush   = st_reg.flush;

endmodule // iac_abort_status

// ---- hw/iac_line_sync.sv ----
// two-flop synchroniser for the bus lines and rising edge finder for SCL
`timescale 1ns/1ps
module iac_line_sync (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_rise,
  output logic      sda_level
);

  // ******************************************************************
  // state
  // ******************************************************************
  typedef struct packed {
    logic scl_meta;
    logic scl_sync;
    logic scl_prev;
    logic sda_meta;
    logic sda_sync;
  } iac_sync_state_t;

  iac_sync_state_t st_reg;
  iac_sync_state_t st_next;

  always_comb begin
    st_next          = st_reg;
    st_next.scl_meta = scl_in;
    st_next.scl_sync = st_reg.scl_meta;
    st_next.scl_prev = st_reg.scl_sync;
    st_next.sda_meta = sda_in;
    st_next.sda_sync = st_reg.sda_meta;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      // lines idle high, so no false rise right after reset
      st_reg <= 5'h1F;
    end else begin
      st_reg <= st_next;
    end
  end

  // the second stages are looked at, plus scl_prev, a third SCL flop, for the rising edge
  assign scl_rise  = st_reg.scl_sync & ~st_reg.scl_prev;
  assign sda_level = st_reg.sda_sync;

endmodule // iac_line_sync

// ---- hw/iac_pkg.sv ----
// constants, types and register map of the abort cause and fifo level block
package iac_pkg;

  // ******************************************************************
  // register map
  // ******************************************************************
  localparam logic [31:0] RX_FIFO_FILL_COUNT_OFS = 32'h5000_1378;
  localparam logic [31:0] SDA_HOLD_TIME_OFS      = 32'h5000_137C;
  localparam logic [31:0] TX_ABORT_CAUSE_OFS     = 32'h5000_1380;
  localparam logic [31:0] TX_ABORT_CLEAR_OFS     = 32'h5000_13C0;
  localparam logic [31:0] UNMAPPED_RDATA         = 32'h0000_0000;

  localparam logic [15:0] SDA_HOLD_RST    = 16'h0001;
  localparam logic [15:0] ABORT_CAUSE_RST = 16'h0000;
  localparam logic [5:0]  RX_COUNT_RST    = 6'h00;
  localparam int unsigned RX_COUNT_W      = 6;

  // ******************************************************************
  // abort cause bit positions
  // ******************************************************************
  localparam int unsigned SLAVE_READ_CMD_CONFLICT    = 15;
  localparam int unsigned SLAVE_TX_BUS_LOST          = 14;
  localparam int unsigned SLAVE_STALE_TX_FLUSH       = 13;
  localparam int unsigned ARBITRATION_LOST           = 12;
  localparam int unsigned MASTER_DISABLED_ATTEMPT    = 11;
  localparam int unsigned TENBIT_READ_NO_RESTART     = 10;
  localparam int unsigned STARTBYTE_NO_RESTART       = 9;
  localparam int unsigned HIGHSPEED_NO_RESTART       = 8;
  localparam int unsigned STARTBYTE_ACKED            = 7;
  localparam int unsigned HIGHSPEED_CODE_ACKED       = 6;
  localparam int unsigned GCALL_FOLLOWED_BY_READ     = 5;
  localparam int unsigned GCALL_UNACKED              = 4;
  localparam int unsigned TX_DATA_UNACKED            = 3;
  localparam int unsigned TENBIT_ADDR_SECOND_UNACKED = 2;
  localparam int unsigned TENBIT_ADDR_FIRST_UNACKED  = 1;
  localparam int unsigned SEVENBIT_ADDR_UNACKED      = 0;

  // ******************************************************************
  // types
  // ******************************************************************
  typedef enum logic [2:0] {
    IAC_PH_ADDR7   = 3'h0,
    IAC_PH_ADDR10A = 3'h1,
    IAC_PH_ADDR10B = 3'h2,
    IAC_PH_GCALL   = 3'h3,
    IAC_PH_SBYTE   = 3'h4,
    IAC_PH_HSCODE  = 3'h5,
    IAC_PH_DATA    = 3'h6
  } iac_phase_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } iac_bus_req_t;

  typedef struct packed {
    logic repeated_start_allow;
    logic master_enable;
    logic command_select_a;
    logic gcall_or_startbyte_select;
    logic tenbit_addr;
    logic highspeed;
  } iac_ctrl_t;

  typedef struct packed {
    logic       master_start;
    logic       master_req_pending;
    logic       first_cmd_read;
    logic       cmd_write;
    logic       cmd_read_bit;
    logic       slave_read_req;
    logic       slave_read_cmd_rx;
    logic       tx_fifo_nonempty;
    logic       master_tx;
    logic       slave_tx;
    logic       intended_sda;
    logic       ack_strobe;
    iac_phase_t ack_phase;
    logic       acked;
    logic       next_cmd_bit9;
  } iac_evt_t;

endpackage

// ---- verif/iac_abort_status_chk.sv ----
// assertions on the abort cause recorder ports
`timescale 1ns/1ps
module iac_abort_status_chk (
  input wire logic                  clock,
  input wire logic                  nrst,
  input wire iac_pkg::iac_bus_req_t bus_req,
  input wire logic [31:0]           rd_data,
  input wire iac_pkg::iac_ctrl_t    ctrl,
  input wire iac_pkg::iac_evt_t     evt,
  input wire logic [5:0]            rx_fifo_count,
  input wire logic [15:0]           tx_abort_cause,
  input wire logic                  tx_abort_event,
  input wire logic                  tx_fifo_flush
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_addr7; evt.ack_strobe && evt.ack_phase == iac_pkg::IAC_PH_ADDR7 && !evt.acked
    |=> tx_abort_cause[0]; endproperty
  a_addr7: assert property (p_addr7) else $error("address nack not recorded");
  property p_data; evt.ack_strobe && evt.ack_phase == iac_pkg::IAC_PH_DATA && !evt.acked
    |=> tx_abort_cause[3]; endproperty
  a_data: assert property (p_data) else $error("data nack not recorded");
  property p_mdis; evt.master_start && !ctrl.master_enable |=> tx_abort_cause[11]; endproperty
  a_mdis: assert property (p_mdis) else $error("disabled master start missed");
  property p_slvrd; evt.cmd_write && evt.cmd_read_bit && evt.slave_read_req
    |=> tx_abort_cause[15]; endproperty
  a_slvrd: assert property (p_slvrd) else $error("slave read conflict missed");
  property p_stale; evt.slave_read_cmd_rx && evt.tx_fifo_nonempty
    |=> tx_abort_cause[13]; endproperty
  a_stale: assert property (p_stale) else $error("stale tx flush missed");
  property p_pair; $rose(tx_abort_cause[14]) |-> tx_abort_cause[12]; endproperty
  a_pair: assert property (p_pair) else $error("slave loss without bit 12");
  property p_flush; (tx_abort_cause & ~$past(tx_abort_cause)) != 16'h0000
    |-> tx_fifo_flush && tx_abort_event; endproperty
  a_flush: assert property (p_flush) else $error("new cause without flush");
  property p_rxcnt; bus_req.rd && bus_req.addr == iac_pkg::RX_FIFO_FILL_COUNT_OFS
    |=> rd_data == {26'h0000000, $past(rx_fifo_count, 2)}; endproperty
  a_rxcnt: assert property (p_rxcnt) else $error("receive level read wrong");
  // bit 9 follows its cause unless cleared in the same cycle
  property p_sb; evt.master_req_pending && !ctrl.repeated_start_allow &&
    ctrl.command_select_a && ctrl.gcall_or_startbyte_select &&
    !(bus_req.wr && bus_req.addr == iac_pkg::TX_ABORT_CLEAR_OFS)
    |=> tx_abort_cause[9]; endproperty
  a_sb: assert property (p_sb) else $error("start byte cause not held");
endmodule // iac_abort_status_chk

// ---- verif/iac_abort_status_tb.sv ----
// self-checking bench for the abort cause recorder
`timescale 1ns/1ps
`define IAC_CHK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module iac_abort_status_tb;
  localparam iac_pkg::iac_ctrl_t CTRL_IDLE = 6'h30;
  logic                  clock;
  logic                  nrst;
  iac_pkg::iac_bus_req_t bus_req;
  iac_pkg::iac_ctrl_t    ctrl;
  iac_pkg::iac_evt_t     evt;
  logic [5:0]            rx_fifo_count;
  logic                  scl_in;
  logic                  sda_in;
  logic [31:0]           rd_data;
  logic [15:0]           tx_abort_cause;
  logic [15:0]           sda_hold_cycles;
  logic                  tx_abort_event;
  logic                  tx_fifo_flush;
  logic [15:0]           lfsr;
  int                    num_errors;
  int                    compares;
  int                    ids [14] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 10, 11, 13, 15, 16};
  iac_pkg::iac_phase_t   ph [8] = '{iac_pkg::IAC_PH_ADDR7, iac_pkg::IAC_PH_ADDR10A,
    iac_pkg::IAC_PH_ADDR10B, iac_pkg::IAC_PH_DATA, iac_pkg::IAC_PH_GCALL,
    iac_pkg::IAC_PH_GCALL, iac_pkg::IAC_PH_HSCODE, iac_pkg::IAC_PH_SBYTE};

  iac_abort_status i_iac_abort_status (.clock(clock), .nrst(nrst), .bus_req(bus_req),
    .rd_data(rd_data), .ctrl(ctrl), .evt(evt), .rx_fifo_count(rx_fifo_count),
    .scl_in(scl_in), .sda_in(sda_in), .sda_hold_cycles(sda_hold_cycles),
    .tx_abort_cause(tx_abort_cause),
    .tx_abort_event(tx_abort_event), .tx_fifo_flush(tx_fifo_flush));
  iac_remote_dev i_iac_remote_dev (.clock(clock), .scl(scl_in), .sda(sda_in));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] cause_for(input int i);
    return (i > 15) ? 16'h0000 : 16'h0001 << i;
  endfunction

  task automatic final_report;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 32'h00000000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    @(negedge clock);
    `IAC_CHK(rd_data, exp)
  endtask
  // one event for one cycle from a clean cause register; 16 is a harmless ack
  task automatic fire(input int i);
    iac_pkg::iac_evt_t  e;
    iac_pkg::iac_ctrl_t c;
    e = '0;
    c = CTRL_IDLE;
    e.ack_strobe = (i < 8) || (i == 16);
    e.ack_phase = (i < 8) ? ph[i] : iac_pkg::IAC_PH_ADDR7;
    e.acked = i inside {5, 6, 7, 16};
    e.next_cmd_bit9 = (i == 5);
    e.master_start = i inside {8, 10, 11};
    c.repeated_start_allow = !(i inside {8, 10});
    c.highspeed = (i == 8);
    c.tenbit_addr = (i == 10);
    e.first_cmd_read = (i == 10);
    c.master_enable = (i != 11);
    e.slave_read_cmd_rx = (i == 13);
    e.tx_fifo_nonempty = (i == 13);
    e.slave_read_req = (i == 15);
    e.cmd_write = (i == 15);
    e.cmd_read_bit = (i == 15);
    lfsr = lfsr_next(lfsr);
    wr(iac_pkg::TX_ABORT_CLEAR_OFS, {16'h0000, lfsr});
    @(posedge clock);
    evt <= e;
    ctrl <= c;
    @(posedge clock);
    evt <= '0;
    ctrl <= CTRL_IDLE;
    @(negedge clock);
    `IAC_CHK(tx_fifo_flush, 1'(i != 16))
    `IAC_CHK(tx_abort_event, 1'(i != 16))
    `IAC_CHK(tx_abort_cause, cause_for(i))
    rd(iac_pkg::TX_ABORT_CAUSE_OFS, {16'h0000, cause_for(i)});
  endtask
  task automatic line_bit(input logic stx, input logic b, input int gap, input logic [15:0] exp);
    wr(iac_pkg::TX_ABORT_CLEAR_OFS, 32'h00000000);
    @(posedge clock);
    evt.master_tx <= !stx;
    evt.slave_tx <= stx;
    evt.intended_sda <= 1'b1;
    i_iac_remote_dev.send_bit(b, gap);
    repeat (4) @(posedge clock);
    evt <= '0;
    @(negedge clock);
    `IAC_CHK(tx_abort_cause, exp)
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    final_report();
  end
  initial begin
    nrst = 1'b0;
    bus_req = '0;
    ctrl = CTRL_IDLE;
    evt = '0;
    rx_fifo_count = 6'h00;
    lfsr = 16'h002C;
    num_errors = 0;
    compares = 0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    rd(iac_pkg::SDA_HOLD_TIME_OFS, 32'h00000001);
    rd(iac_pkg::TX_ABORT_CAUSE_OFS, 32'h00000000);
    rd(iac_pkg::RX_FIFO_FILL_COUNT_OFS, 32'h00000000);
    rd(32'h50001384, 32'h00000000);
    for (int k = 0; k < 6; k++) begin
      lfsr = lfsr_next(lfsr);
      @(posedge clock);
      rx_fifo_count <= (k == 0) ? 6'h3F : lfsr[5:0];
      wr(iac_pkg::SDA_HOLD_TIME_OFS, {16'h0000, lfsr});
      wr(iac_pkg::RX_FIFO_FILL_COUNT_OFS, 32'hFFFFFFFF);
      rd(iac_pkg::RX_FIFO_FILL_COUNT_OFS, {26'h0000000, (k == 0) ? 6'h3F : lfsr[5:0]});
      `IAC_CHK(sda_hold_cycles, lfsr)
      rd(iac_pkg::SDA_HOLD_TIME_OFS, {16'h0000, lfsr});
    end
    foreach (ids[n]) fire(ids[n]);
    // start byte with no repeated start: clear cannot stick while cause stays
    @(posedge clock);
    ctrl <= 6'h1C;
    evt.master_req_pending <= 1'b1;
    repeat (2) @(posedge clock);
    wr(iac_pkg::TX_ABORT_CLEAR_OFS, 32'h00000000);
    @(negedge clock);
    `IAC_CHK(tx_abort_cause[9], 1'b0)
    @(negedge clock);
    `IAC_CHK(tx_abort_cause[9], 1'b1)
    @(posedge clock);
    ctrl <= CTRL_IDLE;
    evt <= '0;
    wr(iac_pkg::TX_ABORT_CLEAR_OFS, 32'h00000000);
    repeat (2) @(negedge clock);
    `IAC_CHK(tx_abort_cause, 16'h0000)
    line_bit(1'b0, 1'b1, 1, 16'h0000);
    line_bit(1'b0, 1'b0, 1, 16'h1000);
    line_bit(1'b1, 1'b0, 3, 16'h5000);
    final_report();
  end
endmodule // iac_abort_status_tb

bind iac_abort_status iac_abort_status_chk i_iac_abort_status_chk (.clock(clock),
  .nrst(nrst), .bus_req(bus_req), .rd_data(rd_data), .ctrl(ctrl), .evt(evt),
  .rx_fifo_count(rx_fifo_count), .tx_abort_cause(tx_abort_cause),
  .tx_abort_event(tx_abort_event), .tx_fifo_flush(tx_fifo_flush));

// ---- verif/iac_remote_dev.sv ----
// remote bus device driving the clock and data lines
`timescale 1ns/1ps
module iac_remote_dev (
  input  wire logic clock,
  output logic      scl,
  output logic      sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // gap sets how slow the remote is; data only moves while clock low
  task automatic send_bit(input logic b, input int gap);
    @(posedge clock);
    scl <= 1'b0;
    repeat (gap) @(posedge clock);
    sda <= b;
    repeat (gap) @(posedge clock);
    scl <= 1'b1;
    repeat (gap) @(posedge clock);
    scl <= 1'b0;
    repeat (gap) @(posedge clock);
    sda <= 1'b1; // released, pull-up
    repeat (gap) @(posedge clock);
    scl <= 1'b1;
  endtask
endmodule // iac_remote_dev
